// [rtl/ccs_clock_select.sv]
// core clock source select, oscillator monitor and apb registers
`timescale 1ns/10ps
module ccs_clock_select (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic [2:0]               clock_mode_strap_pins,
  input  wire logic                     crystal_input_pin,
  input  wire logic                     sw_reset,
  input  wire ccs_pkg::ccs_apb_req_type apb_req,
  output ccs_pkg::ccs_apb_rsp_type      apb_rsp,
  output logic                          core_clk,
  output logic                          core_edge,
  output logic                          pll_running,
  output logic                          irq
);

  function automatic ccs_pkg::ccs_mode_type mode_of(input logic [2:0] code);
    if (code == ccs_pkg::CODE_DIRECT) begin
      mode_of = ccs_pkg::MODE_DIRECT;
    end else if (code == ccs_pkg::CODE_PRESCALE) begin
      mode_of = ccs_pkg::MODE_PRESCALE;
    end else begin
      mode_of = ccs_pkg::MODE_PLL;
    end
  endfunction

  function automatic logic [4:0] factor_of(input logic [2:0] code);
    case (code)
      3'h7:    factor_of = 5'h04;
      3'h6:    factor_of = 5'h03;
      3'h5:    factor_of = 5'h08;
      3'h4:    factor_of = 5'h05;
      3'h2:    factor_of = 5'h0A;
      3'h0:    factor_of = 5'h10;
      default: factor_of = 5'h01;
    endcase
  endfunction

  // core half period in clk cycles for one input period and factor
  function automatic logic [15:0] half_of(input logic [15:0] per,
                                           input logic [4:0]  f);
    logic [15:0] h;
    h = per / {10'h000, f, 1'b0};
    half_of = (h == 16'h0000) ? 16'h0001 : h;
  endfunction

  // reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // strap capture while reset is still held internally
  logic [2:0] strap_d, strap_q;

  always_comb begin
    strap_d = strap_q;
    if (!rst_n || sw_reset) begin
      strap_d = clock_mode_strap_pins;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_q <= ccs_pkg::STRAP_RESET;
    end else begin
      strap_q <= strap_d;
    end
  end

  ccs_pkg::ccs_mode_type mode;
  logic [4:0]            factor;
  assign mode   = mode_of(strap_q);
  assign factor = factor_of(strap_q);

  // register state
  logic [31:0]           cfg_d, cfg_q;
  logic [1:0]            stat_d, stat_q;
  logic [1:0]            mask_d, mask_q;
  logic [1:0]            snap_d, snap_q;
  ccs_pkg::ccs_apb_rsp_type rsp_d, rsp_q;
  logic                  irq_d, irq_q;

  // clock state
  logic              xt_q, xt_prev_q;
  logic              xt_edge, xt_rise;
  logic [2:0]        tick_cnt_d, tick_cnt_q;
  logic              pll_tick;
  logic              pll_on;
  logic              mon_dis;
  logic              mon_active;
  logic              pend_d, pend_q;
  logic [3:0]        mon_cnt_d, mon_cnt_q;
  logic [7:0]        lock_cnt_d, lock_cnt_q;
  logic              osc_fail, unlock;
  logic              failed_d, failed_q;
  logic              unlocked_d, unlocked_q;
  logic              backup;
  logic [15:0]       per_cnt_d, per_cnt_q;
  logic [15:0]       meas_d, meas_q;
  logic [15:0]       half_cnt_d, half_cnt_q;
  logic [15:0]       cur_half_d, cur_half_q;
  logic [15:0]       target_d, target_q;
  logic [4:0]        trans_d, trans_q;
  logic              core_d, core_q;
  logic              edge_d, edge_q;
  logic              pll_run_d, pll_run_q;

  assign xt_edge  = xt_q ^ xt_prev_q;
  assign xt_rise  = xt_q & ~xt_prev_q;
  assign mon_dis  = cfg_q[ccs_pkg::CFG_MON_DIS_BIT];
  assign backup   = failed_q | unlocked_q;
  // monitor never in PLL mode; disabled by config bit
  assign mon_active = (mode != ccs_pkg::MODE_PLL) && !mon_dis
                      && !failed_q;
  // PLL off only in non-PLL mode with monitor disabled
  assign pll_on   = (mode == ccs_pkg::MODE_PLL) || !mon_dis
                    || backup;
  assign pll_tick = pll_on
                    && (tick_cnt_q == 3'(ccs_pkg::PLL_TICK_CYC - 1));

  // free running pll clock divider and oscillator monitor
  always_comb begin
    tick_cnt_d = tick_cnt_q;
    pend_d     = pend_q;
    mon_cnt_d  = mon_cnt_q;
    lock_cnt_d = lock_cnt_q;
    osc_fail   = 1'b0;
    unlock     = 1'b0;
    if (!pll_on) begin
      tick_cnt_d = 3'h0;
    end else if (pll_tick) begin
      tick_cnt_d = 3'h0;
    end else begin
      tick_cnt_d = tick_cnt_q + 3'h1;
    end
    // transitions held until the next pll clock
    if (xt_edge) begin
      pend_d = 1'b1;
    end
    if (pll_tick) begin
      pend_d = xt_edge;
      if (pend_q || xt_edge || !mon_active) begin
        mon_cnt_d = 4'h0;
      end else if (mon_cnt_q == ccs_pkg::MON_LAST) begin
        osc_fail  = 1'b1;
        mon_cnt_d = 4'h0;
      end else begin
        mon_cnt_d = mon_cnt_q + 4'h1;
      end
      if (pend_q || xt_edge || mode != ccs_pkg::MODE_PLL || unlocked_q) begin
        lock_cnt_d = 8'h00;
      end else if (lock_cnt_q == ccs_pkg::LOCK_LOSS_TICKS) begin
        unlock     = 1'b1;
        lock_cnt_d = 8'h00;
      end else begin
        lock_cnt_d = lock_cnt_q + 8'h01;
      end
    end
  end

  // source latches; only a reset returns to the input clock
  always_comb begin
    failed_d   = failed_q;
    unlocked_d = unlocked_q;
    if (sw_reset) begin
      failed_d   = 1'b0;
      unlocked_d = 1'b0;
    end else begin
      if (osc_fail) begin
        failed_d = 1'b1;
      end
      if (unlock) begin
        unlocked_d = 1'b1;
      end
    end
  end

  // core clock generation
  always_comb begin
    per_cnt_d  = per_cnt_q;
    meas_d     = meas_q;
    half_cnt_d = half_cnt_q + 16'h0001;
    cur_half_d = cur_half_q;
    target_d   = target_q;
    trans_d    = trans_q;
    core_d     = core_q;
    if (xt_rise) begin
      meas_d    = per_cnt_q;
      per_cnt_d = 16'h0001;
    end else if (per_cnt_q != 16'hFFFF) begin
      per_cnt_d = per_cnt_q + 16'h0001;
    end
    if (xt_edge) begin
      if (trans_q + 5'h01 >= factor) begin
        trans_d  = 5'h00;
        target_d = half_of(meas_q, factor);
      end else begin
        trans_d  = trans_q + 5'h01;
      end
    end
    if (backup) begin
      // a switch waits for the next pll clock; after an oscillator failure
      // the old phase has already lasted at least a full monitor window
      if (pll_tick) begin
        core_d = ~core_q;
      end
    end else begin
      case (mode)
        ccs_pkg::MODE_DIRECT: begin
          core_d = xt_q;
        end
        ccs_pkg::MODE_PRESCALE: begin
          if (xt_rise) begin
            core_d = ~core_q;
          end
        end
        default: begin
          if (half_cnt_q + 16'h0001 >= cur_half_q) begin
            core_d     = ~core_q;
            half_cnt_d = 16'h0000;
            // one cycle step per half keeps the rate change smooth
            if (cur_half_q < target_q) begin
              cur_half_d = cur_half_q + 16'h0001;
            end else if (cur_half_q > target_q) begin
              cur_half_d = cur_half_q - 16'h0001;
            end
          end
        end
      endcase
    end
    edge_d    = core_d ^ core_q;
    pll_run_d = pll_on;
  end

  // apb slave, answers one cycle after the access phase starts
  logic        acc_start, acc_done;
  logic [11:0] addr;
  logic        mapped;
  logic [31:0] rdata;

  assign acc_start = apb_req.psel && apb_req.penable && !rsp_q.pready;
  assign acc_done  = apb_req.psel && apb_req.penable && rsp_q.pready;
  assign addr      = apb_req.paddr;

  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    if (addr == ccs_pkg::ADDR_CFG) begin
      rdata = cfg_q;
    end else if (addr == ccs_pkg::ADDR_STAT) begin
      rdata = {30'h0, stat_q};
    end else if (addr == ccs_pkg::ADDR_MASK) begin
      rdata = {30'h0, mask_q};
    end else if (addr == ccs_pkg::ADDR_MODE) begin
      rdata = {25'h0, pll_on, unlocked_q, failed_q, 1'b0, strap_q};
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    cfg_d  = cfg_q;
    mask_d = mask_q;
    snap_d = snap_q;
    rsp_d  = '0;
    stat_d = stat_q;
    if (acc_start) begin
      rsp_d.pready  = 1'b1;
      rsp_d.pslverr = !mapped;
      rsp_d.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
      snap_d = (!apb_req.pwrite && addr == ccs_pkg::ADDR_STAT) ? stat_q
               : 2'h0;
    end
    if (acc_done) begin
      if (apb_req.pwrite && addr == ccs_pkg::ADDR_CFG) begin
        cfg_d = {27'h0, apb_req.pwdata[ccs_pkg::CFG_MON_DIS_BIT], 4'h0};
      end
      if (apb_req.pwrite && addr == ccs_pkg::ADDR_MASK) begin
        mask_d = apb_req.pwdata[1:0];
      end
      // read clears only the bits that were returned
      stat_d = stat_q & ~snap_q;
      snap_d = 2'h0;
    end
    // new events win over the clear
    if (osc_fail) begin
      stat_d[ccs_pkg::STAT_OSC_FAIL] = 1'b1;
    end
    if (unlock) begin
      stat_d[ccs_pkg::STAT_UNLOCK] = 1'b1;
    end
    irq_d = |(stat_d & mask_d);
  end

  // register file and bus response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q      <= ccs_pkg::CFG_RESET;
      stat_q     <= 2'h0;
      mask_q     <= ccs_pkg::MASK_RESET;
      snap_q     <= 2'h0;
      rsp_q      <= '0;
      irq_q      <= 1'b0;
    end else begin
      cfg_q      <= cfg_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      snap_q     <= snap_d;
      rsp_q      <= rsp_d;
      irq_q      <= irq_d;
    end
  end

  // input sampling, pll divider and monitor counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xt_q       <= 1'b0;
      xt_prev_q  <= 1'b0;
      tick_cnt_q <= 3'h0;
      pend_q     <= 1'b0;
      mon_cnt_q  <= 4'h0;
      lock_cnt_q <= 8'h00;
    end else begin
      xt_q       <= crystal_input_pin;
      xt_prev_q  <= xt_q;
      tick_cnt_q <= tick_cnt_d;
      pend_q     <= pend_d;
      mon_cnt_q  <= mon_cnt_d;
      lock_cnt_q <= lock_cnt_d;
    end
  end

  // backup source latches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      failed_q   <= 1'b0;
      unlocked_q <= 1'b0;
    end else begin
      failed_q   <= failed_d;
      unlocked_q <= unlocked_d;
    end
  end

  // core clock generator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_q  <= 16'h0000;
      meas_q     <= 16'h0000;
      half_cnt_q <= 16'h0000;
      cur_half_q <= ccs_pkg::HALF_RESET;
      target_q   <= ccs_pkg::HALF_RESET;
      trans_q    <= 5'h00;
      core_q     <= 1'b0;
      edge_q     <= 1'b0;
      pll_run_q  <= 1'b0;
    end else begin
      per_cnt_q  <= per_cnt_d;
      meas_q     <= meas_d;
      half_cnt_q <= half_cnt_d;
      cur_half_q <= cur_half_d;
      target_q   <= target_d;
      trans_q    <= trans_d;
      core_q     <= core_d;
      edge_q     <= edge_d;
      pll_run_q  <= pll_run_d;
    end
  end

  assign apb_rsp     = rsp_q;
  assign irq         = irq_q;
  assign core_clk    = core_q;
  assign core_edge   = edge_q;
  assign pll_running = pll_run_q;

endmodule

// [rtl/ccs_pkg.sv]
// constants and types for the core clock source select block
package ccs_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned PLL_FREE_NS    = 20;
  localparam int unsigned PLL_TICK_CYC   = PLL_FREE_NS / CLK_PERIOD_NS;

  localparam logic [3:0]  MON_LAST       = 4'hF;
  localparam logic [7:0]  LOCK_LOSS_TICKS = 8'h40;

  localparam logic [11:0] ADDR_CFG       = 12'h000;
  localparam logic [11:0] ADDR_STAT      = 12'h004;
  localparam logic [11:0] ADDR_MASK      = 12'h008;
  localparam logic [11:0] ADDR_MODE      = 12'h00C;

  localparam int unsigned CFG_MON_DIS_BIT = 4;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam int unsigned STAT_OSC_FAIL  = 0;
  localparam int unsigned STAT_UNLOCK    = 1;
  localparam logic [1:0]  MASK_RESET     = 2'h0;

  localparam logic [2:0]  STRAP_RESET    = 3'h7;
  localparam logic [2:0]  CODE_DIRECT    = 3'h3;
  localparam logic [2:0]  CODE_PRESCALE  = 3'h1;

  localparam int unsigned CNT_W          = 16;
  localparam logic [15:0] HALF_RESET     = 16'h0004;

  typedef enum logic [1:0] {
    MODE_PLL,
    MODE_DIRECT,
    MODE_PRESCALE
  } ccs_mode_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccs_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ccs_apb_rsp_type;

endpackage

// [verification/ccs_clock_select_bench.sv]
// self-checking bench for the core clock select block
`timescale 1ns/10ps
module ccs_clock_select_bench;
  logic                     clk = 1'b0;
  logic                     rst_b;
  logic                     sw_reset;
  logic                     run;
  logic [2:0]               strap;
  int                       hi;
  int                       lo;
  ccs_pkg::ccs_apb_req_type req;
  ccs_pkg::ccs_apb_rsp_type rsp;
  logic                     xtal;
  logic                     core_clk;
  logic                     pll_running;
  logic                     irq;
  logic [31:0]              rdat;
  logic                     rerr;
  int                       mismatches = 0;
  int                       n_tests = 0;
  always #2.5 clk = ~clk;
  ccs_xtal_model u_xtal (.clk(clk), .run(run), .hi_cyc(hi), .lo_cyc(lo),
    .xtal(xtal));
  ccs_clock_select DUT (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .clock_mode_strap_pins (strap),
    .crystal_input_pin     (xtal),
    .sw_reset              (sw_reset),
    .apb_req               (req),
    .apb_rsp               (rsp),
    .core_clk              (core_clk),
    .core_edge             (),
    .pll_running           (pll_running),
    .irq                   (irq)
  );
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(posedge clk);
    rst_b <= 1'b0;
    strap <= s;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    if (rsp.pready !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t no pready", $time);
    end
    req <= '0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic span(input logic v, output int c);
    c = 0;
    while (core_clk === v && c < 800) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic meas(input int eh, input int el);
    int h;
    int l;
    span(1'b1, h);
    span(1'b0, l);
    span(1'b1, h);
    span(1'b0, l);
    chk(h, eh);
    chk(l, el);
  endtask
  task automatic t_direct;
    int n;
    hi <= 8;
    lo <= 16;
    run <= 1'b1;
    do_reset(3'h3);
    rd_chk(ccs_pkg::ADDR_CFG, 32'h0);
    rd_chk(ccs_pkg::ADDR_MASK, 32'h0);
    rd_chk(ccs_pkg::ADDR_STAT, 32'h0);
    rd_chk(ccs_pkg::ADDR_MODE, 32'h43);
    meas(8, 16);
    apb(1'b1, ccs_pkg::ADDR_MASK, 32'h1);
    meas(8, 16);
    run <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(n inside {[58:76]}, 1);
    rd_chk(ccs_pkg::ADDR_STAT, 32'h1);
    repeat (3) @(posedge clk);
    chk(irq, 0);
    run <= 1'b1;
    meas(4, 4);
    rd_chk(ccs_pkg::ADDR_MODE, 32'h53);
    sw_reset <= 1'b1;
    @(posedge clk);
    sw_reset <= 1'b0;
    repeat (8) @(posedge clk);
    meas(8, 16);
    rd_chk(ccs_pkg::ADDR_MODE, 32'h43);
  endtask
  task automatic t_presc;
    hi <= 6;
    lo <= 6;
    run <= 1'b1;
    do_reset(3'h1);
    meas(12, 12);
    run <= 1'b0;
    repeat (120) @(posedge clk);
    chk(irq, 0);
    rd_chk(ccs_pkg::ADDR_STAT, 32'h1);
    rd_chk(ccs_pkg::ADDR_MODE, 32'h51);
    meas(4, 4);
  endtask
  task automatic t_mondis;
    hi <= 12;
    lo <= 12;
    run <= 1'b1;
    do_reset(3'h3);
    apb(1'b1, ccs_pkg::ADDR_CFG, 32'hFFFF_FFFF);
    apb(1'b1, 12'h010, 32'h0);
    chk(rerr, 1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rerr, 1);
    chk(rdat, 0);
    rd_chk(ccs_pkg::ADDR_CFG, 32'h10);
    chk(pll_running, 0);
    run <= 1'b0;
    repeat (150) @(posedge clk);
    rd_chk(ccs_pkg::ADDR_STAT, 32'h0);
    rd_chk(ccs_pkg::ADDR_MODE, 32'h3);
    apb(1'b1, ccs_pkg::ADDR_CFG, 32'h0);
    repeat (4) @(posedge clk);
    chk(pll_running, 1);
  endtask
  task automatic t_pll;
    logic [2:0] codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h0, 3'h2};
    int         fac [6] = '{4, 3, 8, 5, 16, 10};
    for (int i = 0; i < 6; i++) begin
      hi <= 6 * fac[i];
      lo <= 6 * fac[i];
      run <= 1'b1;
      do_reset(codes[i]);
      rd_chk(ccs_pkg::ADDR_MODE, {25'h0, 4'h8, codes[i]});
      repeat (192 * fac[i]) @(posedge clk);
      meas(6, 6);
    end
    apb(1'b1, ccs_pkg::ADDR_MASK, 32'h2);
    run <= 1'b0;
    repeat (150) @(posedge clk);
    chk(irq, 0);
    rd_chk(ccs_pkg::ADDR_STAT, 32'h0);
    repeat (250) @(posedge clk);
    chk(irq, 1);
    rd_chk(ccs_pkg::ADDR_STAT, 32'h2);
    meas(4, 4);
  endtask
  initial begin
    rst_b = 1'b0;
    sw_reset = 1'b0;
    strap = 3'h7;
    req = '0;
    run = 1'b0;
    hi = 12;
    lo = 12;
    t_direct;
    t_presc;
    t_mondis;
    t_pll;
    report_and_stop;
  end
  // the tests take about 10000 cycles
  initial begin
    #400000;
    mismatches++;
    report_and_stop;
  end
endmodule

// [verification/ccs_clock_select_chk.sv]
// port assertions for the core clock select block
`timescale 1ns/10ps
module ccs_clock_select_chk (
  input wire logic                     clk,
  input wire logic                     rst_b,
  input wire logic [2:0]               clock_mode_strap_pins,
  input wire logic                     sw_reset,
  input wire ccs_pkg::ccs_apb_req_type apb_req,
  input wire ccs_pkg::ccs_apb_rsp_type apb_rsp,
  input wire logic                     core_clk,
  input wire logic                     core_edge,
  input wire logic                     pll_running
);
  logic [3:0] up_q;
  logic [3:0] up_d;
  logic [4:0] half_q;
  logic [4:0] half_d;
  logic       clk_q;
  logic       seen_q;
  logic       seen_d;
  logic       dis_q;
  logic       dis_d;
  logic       chg;
  logic       acc;
  logic       npll;
  assign chg  = core_clk ^ clk_q;
  assign acc  = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign npll = clock_mode_strap_pins inside {3'h1, 3'h3};
  always_comb begin
    up_d   = (up_q == 4'hF) ? up_q : up_q + 4'h1;
    half_d = chg ? 5'h00 : half_q + {4'h0, half_q != 5'h1F};
    seen_d = seen_q | (chg & (up_q == 4'hF));
    dis_d  = dis_q;
    if (acc && apb_req.pwrite && apb_req.paddr == ccs_pkg::ADDR_CFG)
      dis_d = apb_req.pwdata[ccs_pkg::CFG_MON_DIS_BIT];
    // halves around a soft reset are not judged
    if (sw_reset) begin
      up_d   = 4'h0;
      seen_d = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_q   <= 4'h0;
      half_q <= 5'h00;
      clk_q  <= 1'b0;
      seen_q <= 1'b0;
      dis_q  <= 1'b0;
    end else begin
      up_q   <= up_d;
      half_q <= half_d;
      clk_q  <= core_clk;
      seen_q <= seen_d;
      dis_q  <= dis_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence pll_stays_off;
    !pll_running [*8];
  endsequence
  wait_state_a: assert property (apb_req.psel && apb_req.penable
    && !apb_rsp.pready |=> apb_rsp.pready) else $error("no wait state");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready too long");
  unmapped_err_a: assert property (acc && apb_req.paddr > ccs_pkg::ADDR_MODE
    |-> apb_rsp.pslverr && (apb_req.pwrite || apb_rsp.prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && apb_req.paddr <= ccs_pkg::ADDR_MODE
    && apb_req.paddr[1:0] == 2'h0 |-> !apb_rsp.pslverr)
    else $error("mapped access refused");
  edge_pulse_a: assert property (
    up_q == 4'hF |-> core_edge == chg) else $error("edge pulse wrong");
  pll_on_a: assert property (
    up_q == 4'hF && !npll |-> pll_running) else $error("pll off in pll mode");
  min_half_a: assert property (
    chg && seen_q && npll |-> half_q >= 5'h03) else $error("short half");
  mon_off_a: assert property (
    npll && $rose(dis_q) |-> ##[1:4] pll_stays_off)
    else $error("pll not off");
  mon_on_a: assert property (
    npll && $fell(dis_q) |-> ##[1:4] pll_running) else $error("pll not on");
endmodule
bind ccs_clock_select ccs_clock_select_chk u_chk (
  .clk                   (clk),
  .rst_b                 (rst_b),
  .clock_mode_strap_pins (clock_mode_strap_pins),
  .sw_reset              (sw_reset),
  .apb_req               (apb_req),
  .apb_rsp               (apb_rsp),
  .core_clk              (core_clk),
  .core_edge             (core_edge),
  .pll_running           (pll_running)
);

// [verification/ccs_xtal_model.sv]
// crystal or external clock source feeding the input pin
`timescale 1ns/10ps
module ccs_xtal_model (
  input  wire logic clk,
  input  wire logic run,
  input  var int    hi_cyc,
  input  var int    lo_cyc,
  output logic      xtal
);
  int cnt;
  initial xtal = 1'b0;
  initial cnt = 0;
  // a dead source holds its last level
  always @(posedge clk) begin
    if (run) begin
      cnt <= cnt + 1;
      if (cnt + 1 >= (xtal ? hi_cyc : lo_cyc)) begin
        xtal <= ~xtal;
        cnt  <= 0;
      end
    end
  end
endmodule
